//--- bench/mcu_spi_model.sv
`timescale 1ns/100ps
// ==========================================================
// controller as spi master, link clock idle low
module mcu_spi_model
(
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n_o = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_o = w[i];
      #100 sck_o = 1'b1;
      #100 r[i] = miso_i;
      sck_o = 1'b0;
    end
    #200 cs_n_o = 1'b1;
    mosi_o = ~w[0];
  endtask : xfer
endmodule : mcu_spi_model

//--- bench/sbc_mode_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// port checker
module sbc_mode_assertions
  import sbc_mode_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       main_supply_ok_i,
  input wire logic       batt_ok_i,
  input wire logic       wake_can_i,
  input wire logic       reset_output_n_o,
  input wire logic       int_n_o,
  input wire logic [2:0] fail_outputs_o,
  input wire logic [1:0] mode_bits_o,
  input wire logic [2:0] state_o,
  input wire logic       dev_config_o,
  input wire logic       wd_fail_o,
  input wire logic       main_supply_undervoltage_flag_o,
  input wire logic       aux_supply_en_o,
  input wire logic       boost_en_o,
  input wire logic [1:0] can_mode_o,
  input wire logic [1:0] lin_mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // counts cycles with reset output low
  logic [9:0] low_q;
  logic [9:0] low_d;
  assign low_d = reset_output_n_o ? 10'h0 :
                 (&low_q) ? low_q : low_q + 10'h1;
  always_ff @(posedge mclk_i)
    low_q <= low_d;
  sequence in_restart;
    (state_o == ST_RESTART) [*2];
  endsequence
  sequence in_stop;
    (state_o == ST_STOP) [*2];
  endsequence
  chk_supply_low_rst :
    assert property (!main_supply_ok_i [*4] |-> !reset_output_n_o)
    else $error("reset released with supply low");
  chk_release_delay :
    assert property ($rose(reset_output_n_o) |-> low_q >= RD_CYC)
    else $error("reset released before delay");
  chk_powerup_quiet :
    assert property (state_o == ST_INIT && !main_supply_ok_i &&
      !batt_ok_i |-> !main_supply_undervoltage_flag_o &&
      fail_outputs_o == 3'h0)
    else $error("flag or fail output during power-up");
  chk_init_wake_drop :
    assert property (state_o == ST_INIT |-> int_n_o)
    else $error("interrupt in init mode");
  chk_restart_mode_clear :
    assert property (in_restart |-> mode_bits_o == MODE_NORMAL)
    else $error("mode bits kept in restart");
  chk_restart_reset_low :
    assert property (in_restart |-> !reset_output_n_o)
    else $error("reset high in restart");
  chk_stop_frozen :
    assert property (in_stop |-> $stable(aux_supply_en_o) &&
      $stable(boost_en_o) && $stable(can_mode_o) && $stable(lin_mode_o))
    else $error("setting changed in stop");
  chk_dev_no_wd :
    assert property (dev_config_o |-> !wd_fail_o)
    else $error("watchdog failure in development");
  chk_wake_int_normal :
    assert property (state_o == ST_NORMAL && $rose(wake_can_i) |->
      ##[1:10] (!int_n_o && state_o == ST_NORMAL))
    else $error("wake without interrupt");
endmodule : sbc_mode_assertions

bind sbc_mode_ctrl sbc_mode_assertions chk (.*);

//--- bench/sbc_mode_ctrl_bench.sv
`timescale 1ns/100ps
// ==========================================================
// bench top
module sbc_mode_ctrl_bench;
  import sbc_mode_pkg::*;
  localparam int SPAN = 2000 + RD_CYC + 300;
  logic mclk_i, rst_i, sck_i, cs_n_i, mosi_i, miso_o, miso_oe_o;
  logic main_supply_ok_i, batt_ok_i, config_strap_pin_i;
  logic wake_can_i, wake_input_i, reset_output_n_o, int_n_o;
  logic fail_safe_input_active_o, dev_config_o, spi_fail_o, wd_fail_o;
  logic main_supply_undervoltage_flag_o, aux_supply_en_o, boost_en_o;
  logic wake_input_en_o, cyclic_wake_en_o;
  logic [3:0]  wake_lin_i;
  logic [2:0]  fail_outputs_o, state_o;
  logic [1:0]  mode_bits_o, can_mode_o, lin_mode_o;
  logic [15:0] rx;
  int          n_errors, n_checks, c;
  sbc_mode_ctrl #(.LW_CYC(2000), .WD_CYC(500)) uut (.*);
  mcu_spi_model mcu (.miso_i(miso_o), .sck_o(sck_i), .cs_n_o(cs_n_i),
                     .mosi_o(mosi_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic spi(input logic [15:0] w);
    mcu.xfer(w, rx);
    tick(10);
  endtask : spi
  // waits for the reset output level, c = cycles or -1
  task automatic wait_rst(input logic lvl, input int lim);
    for (c = 0; c < lim && reset_output_n_o !== lvl; c++)
      tick(1);
    if (c == lim)
      c = -1;
  endtask : wait_rst
  task automatic power_up(input logic strap);
    rst_i = 1'b1;
    main_supply_ok_i = 1'b0;
    batt_ok_i = 1'b0;
    config_strap_pin_i = strap;
    tick(4);
    rst_i = 1'b0;
    tick(20);
    check({reset_output_n_o, main_supply_undervoltage_flag_o}, 16'h0);
    check(fail_outputs_o, 16'h0);
    main_supply_ok_i = 1'b1;
    batt_ok_i = 1'b1;
    wait_rst(1'b1, 600);
    check(c >= RD_CYC && c <= RD_CYC + 8, 16'h1);
    check(state_o, ST_INIT);
    check(dev_config_o, {15'h0000, ~strap});
  endtask : power_up
  task automatic pulse_wake();
    wake_can_i = 1'b1;
    wake_lin_i[2] = 1'b1;
    tick(6);
    wake_can_i = 1'b0;
    wake_lin_i[2] = 1'b0;
    tick(6);
  endtask : pulse_wake
  // ==========================================================
  // scenarios
  task automatic t_init_normal();
    power_up(1'b1);
    pulse_wake();
    check(int_n_o, 16'h1);
    spi(16'h7f00);
    check(state_o, ST_NORMAL);
    check({aux_supply_en_o, can_mode_o, lin_mode_o}, 16'h0);
    check({miso_oe_o, boost_en_o, wake_input_en_o, cyclic_wake_en_o}, 16'h0);
    check({fail_outputs_o, fail_safe_input_active_o}, 16'h1);
    spi(16'h0100);
    check(rx[15:13], ST_NORMAL);
    pulse_wake();
    check({int_n_o, state_o}, {13'h0, ST_NORMAL});
    spi(16'h863f);
    check(int_n_o, 16'h1);
    spi(16'h8205);
    check({fail_outputs_o[2], fail_outputs_o[0]}, 16'h3);
    spi(16'h8201);
    check(fail_outputs_o, 16'h0);
  endtask : t_init_normal
  task automatic t_stop();
    spi(16'h8701);
    spi(16'h8300);
    spi(16'h8102);
    check(state_o, ST_STOP);
    spi(16'h8300);
    spi(16'h8700);
    check({aux_supply_en_o, spi_fail_o}, 16'h3);
    spi(16'h8300);
    spi(16'h8501);
    check(spi_fail_o, 16'h0);
    pulse_wake();
    check({int_n_o, state_o}, {13'h0, ST_STOP});
    spi(16'h8101);
    check({spi_fail_o, state_o}, {12'h1, ST_RESTART});
    check(mode_bits_o, MODE_NORMAL);
    wait_rst(1'b1, 600);
    check(c > 0 && state_o === ST_NORMAL, 16'h1);
  endtask : t_stop
  task automatic t_watchdog();
    power_up(1'b1);
    wait_rst(1'b0, SPAN);
    check({wd_fail_o, state_o}, {12'h1, ST_RESTART});
    check(fail_outputs_o != 3'h0, 16'h1);
    for (int i = 0; i < 3; i++)
    begin
      wait_rst(1'b1, SPAN);
      wait_rst(1'b0, SPAN);
      check(c > 0, 16'h1);
    end
    wait_rst(1'b1, SPAN);
    spi(16'h8301);
    for (int i = 0; i < 3; i++)
    begin
      wait_rst(1'b0, SPAN);
      check(c >= 0, 16'h1);
      wait_rst(1'b1, SPAN);
    end
    wait_rst(1'b0, 2 * SPAN);
    check({c[15:0], state_o}, {16'hffff, ST_NORMAL});
  endtask : t_watchdog
  task automatic t_select_zero();
    power_up(1'b1);
    spi(16'h8200);
    for (c = 0; c < SPAN && wd_fail_o !== 1'b1; c++)
      tick(1);
    check({wd_fail_o, reset_output_n_o}, 16'h3);
    wait_rst(1'b0, 2 * SPAN);
    check(c >= 0, 16'h1);
  endtask : t_select_zero
  task automatic t_dev();
    power_up(1'b0);
    spi(16'h0000);
    wait_rst(1'b0, SPAN);
    check(c[15:0], 16'hffff);
    spi(16'h8103);
    check({dev_config_o, state_o}, {13'h0, ST_INIT});
    wait_rst(1'b1, 600);
    check(dev_config_o, 16'h0);
  endtask : t_dev
  // ==========================================================
  // sequence and verdict
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    n_errors = 0;
    n_checks = 0;
    rst_i = 1'b1;
    main_supply_ok_i = 1'b0;
    batt_ok_i = 1'b0;
    config_strap_pin_i = 1'b1;
    wake_can_i = 1'b0;
    wake_lin_i = 4'h0;
    wake_input_i = 1'b0;
    t_init_normal();
    t_stop();
    t_watchdog();
    t_select_zero();
    t_dev();
    report_and_stop();
  end
  initial
  begin
    #2_000_000;
    n_errors++;
    report_and_stop();
  end
endmodule : sbc_mode_ctrl_bench

//--- design/sbc_mode_ctrl.sv
`timescale 1ns/100ps
module sbc_mode_ctrl
  import sbc_mode_pkg::*;
#(
  parameter int unsigned LW_CYC = LW_CYC_D,
  parameter int unsigned WD_CYC = WD_CYC_D
)
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic       main_supply_ok_i,
  input  wire logic       batt_ok_i,
  input  wire logic       config_strap_pin_i,
  input  wire logic       wake_can_i,
  input  wire logic [3:0] wake_lin_i,
  input  wire logic       wake_input_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  output logic            reset_output_n_o,
  output logic            int_n_o,
  output logic [2:0]      fail_outputs_o,
  output logic            fail_safe_input_active_o,
  output logic [1:0]      mode_bits_o,
  output logic [2:0]      state_o,
  output logic            dev_config_o,
  output logic            spi_fail_o,
  output logic            wd_fail_o,
  output logic            main_supply_undervoltage_flag_o,
  output logic            aux_supply_en_o,
  output logic            boost_en_o,
  output logic [1:0]      can_mode_o,
  output logic [1:0]      lin_mode_o,
  output logic            wake_input_en_o,
  output logic            cyclic_wake_en_o
);

  // ==========================================================
  // spi receiver
  sbc_state_t st_q;
  logic        frame;
  logic [15:0] rx;
  logic [5:0]  wk_q;
  logic        dev_q, spi_f_q, wd_f_q, uv_q, fail_q;

  wire [15:0] tx_word = {st_q, dev_q, wd_f_q, uv_q, spi_f_q,
                         fail_q, 2'h0, wk_q};

  spi_frame_rx u_rx (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .sck_i     (sck_i),
    .cs_n_i    (cs_n_i),
    .mosi_i    (mosi_i),
    .tx_word_i (tx_word),
    .miso_o    (miso_o),
    .miso_oe_o (miso_oe_o),
    .frame_o   (frame),
    .rx_word_o (rx)
  );

  // ==========================================================
  // pin synchronisers
  logic [8:0] p1_q, p2_q, p3_q, pl_q, pp_q;

  always_ff @(posedge mclk_i)
  begin
    p1_q <= {main_supply_ok_i, batt_ok_i, config_strap_pin_i,
             wake_can_i, wake_lin_i, wake_input_i};
    p2_q <= p1_q;
    p3_q <= p2_q;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pl_q <= 9'h040;
      pp_q <= 9'h040;
    end
    else
    begin
      pl_q <= (p2_q & p3_q) | (pl_q & (p2_q ^ p3_q));
      pp_q <= pl_q;
    end
  end

  wire       sup_ok = pl_q[8];
  wire       bat_ok = pl_q[7];
  wire       strap  = pl_q[6];
  wire [5:0] wk_ev  = pl_q[5:0] & ~pp_q[5:0];

  // ==========================================================
  // command decode
  wire [6:0] addr = rx[ADDR_HI:ADDR_LO];
  wire [7:0] dat  = rx[7:0];
  wire       wr   = frame & rx[WR_BIT];
  wire       in_init = (st_q == ST_INIT);
  wire       in_norm = (st_q == ST_NORMAL);
  wire       in_stop = (st_q == ST_STOP);
  wire       a_mode  = (addr == A_MODE);
  wire       to_slp  = a_mode & (dat[1:0] == MODE_SLEEP);
  wire       stop_ok = (a_mode & ~to_slp) | (addr == A_WATCHDOG_CONTROL_REGISTER)
                     | (addr == A_SYS_STAT) | (addr == A_SPI_STAT)
                     | (addr == A_WK_STAT);
  wire       stop_bad = wr & in_stop & ~stop_ok;
  wire       stop_slp = wr & in_stop & to_slp;
  wire       eff_wr  = wr & (in_init | in_norm | (in_stop & stop_ok));
  wire       cfg_wr  = wr & (in_init | in_norm);
  wire       soft_rst = eff_wr & a_mode & (dat[1:0] == MODE_SRST);
  wire       wd_trig = eff_wr & (addr == A_WATCHDOG_CONTROL_REGISTER);
  wire       clr     = rst_i | soft_rst;

  // ==========================================================
  // timers
  logic [CNT_W-1:0] rd_q, wd_q;
  logic             rel_q, lw_q, cfg_q, fsi_fo_q, fo_test_q, max3_q;
  logic [1:0]       miss_q, rcnt_q, mode_q;
  logic             seen_q, por_q;

  wire in_rst_ph = in_init | (st_q == ST_RESTART);
  // delay counts only with supply up
  wire rd_done   = in_rst_ph & ~rel_q & sup_ok
                 & (rd_q == CNT_W'(RD_CYC - 1));
  wire [CNT_W-1:0] wd_lim = lw_q ? CNT_W'(LW_CYC - 1)
                                 : CNT_W'(WD_CYC - 1);
  wire wd_run  = rel_q & ~dev_q & (in_init | in_norm | in_stop);
  wire wd_exp  = wd_run & ~wd_trig & (wd_q == wd_lim);
  // first miss tolerated on select zero
  wire miss_ok = ~cfg_q & (miss_q == 2'h0);
  wire lim_hit = max3_q & (rcnt_q == MISS_LIMIT);
  wire wd_rst  = wd_exp & ~miss_ok & ~lim_hit;
  wire uv_rst  = rel_q & ~sup_ok & (in_init | in_norm | in_stop);

  always_ff @(posedge mclk_i)
  begin
    if (clr || ~sup_ok || rel_q)
      rd_q <= '0;
    else if (in_rst_ph)
      rd_q <= rd_q + CNT_W'(1);
  end

  always_ff @(posedge mclk_i)
  begin
    if (clr || ~wd_run || wd_trig || wd_exp)
      wd_q <= '0;
    else
      wd_q <= wd_q + CNT_W'(1);
  end

  // ==========================================================
  // mode state machine
  always_ff @(posedge mclk_i)
  begin
    // init after power-on or soft reset
    if (clr)
    begin
      st_q   <= ST_INIT;
      rel_q  <= 1'b0;
      lw_q   <= 1'b1;
      mode_q <= MODE_NORMAL;
    end
    else
    begin
      case (st_q)
        ST_INIT:
        begin
          if (rd_done)
          begin
            rel_q <= 1'b1;
            lw_q  <= 1'b1;
          end
          if (uv_rst || wd_rst)
            st_q <= ST_RESTART;
          else if (frame)
            st_q <= ST_NORMAL;
        end
        ST_NORMAL, ST_STOP:
        begin
          if (uv_rst || wd_rst || stop_slp)
            st_q <= ST_RESTART;
          else if (eff_wr && a_mode)
          begin
            mode_q <= dat[1:0];
            if (dat[1:0] == MODE_STOP)
              st_q <= ST_STOP;
            else if (dat[1:0] == MODE_SLEEP)
              st_q <= ST_SLEEP;
            else
              st_q <= ST_NORMAL;
          end
          if (wd_trig)
            lw_q <= 1'b0;
        end
        ST_SLEEP:
        begin
          if (|wk_q)
            st_q <= ST_RESTART;
        end
        ST_RESTART:
        begin
          if (rd_done)
          begin
            st_q  <= ST_NORMAL;
            rel_q <= 1'b1;
            lw_q  <= 1'b1;
          end
        end
        default:
          st_q <= ST_INIT;
      endcase
      if ((st_q != ST_RESTART) && (uv_rst || wd_rst || stop_slp ||
          (st_q == ST_SLEEP) || (in_norm && eff_wr && to_slp)))
      begin
        rel_q  <= 1'b0;
        mode_q <= MODE_NORMAL;
      end
    end
  end

  // ==========================================================
  // watchdog failure bookkeeping
  always_ff @(posedge mclk_i)
  begin
    if (clr || wd_trig)
    begin
      miss_q <= 2'h0;
      rcnt_q <= 2'h0;
    end
    else if (wd_exp)
    begin
      if (miss_q != MISS_LIMIT)
        miss_q <= miss_q + 2'h1;
      if (wd_rst)
        rcnt_q <= rcnt_q + 2'h1;
    end
  end

  // ==========================================================
  // configuration latch and control bits
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      por_q <= 1'b1;
    else if (soft_rst || (in_init && rd_done))
      por_q <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (clr)
      dev_q <= 1'b0;
    // strap caught at end of monitoring
    else if (in_init && rd_done && por_q)
      dev_q <= ~strap;
  end

  always_ff @(posedge mclk_i)
  begin
    if (clr)
    begin
      cfg_q     <= 1'b1;
      fsi_fo_q  <= 1'b0;
      fo_test_q <= 1'b0;
      max3_q    <= 1'b0;
    end
    else
    begin
      if (cfg_wr && addr == A_HARDWARE_CONTROL_REGISTER)
      begin
        cfg_q     <= dat[HW_CFG_SEL];
        fsi_fo_q  <= dat[HW_FSI_FO];
        fo_test_q <= dat[HW_FO_TEST];
      end
      if (eff_wr && addr == A_WATCHDOG_CONTROL_REGISTER)
        max3_q <= dat[WD_MAX3];
    end
  end

  // ==========================================================
  // supply and transceiver settings
  logic       aux_q, boost_q, wken_q, cyc_q;
  logic [1:0] can_q, lin_q;

  always_ff @(posedge mclk_i)
  begin
    if (clr)
    begin
      aux_q   <= 1'b0;
      boost_q <= 1'b0;
      can_q   <= TRX_OFF;
      lin_q   <= TRX_OFF;
      wken_q  <= 1'b0;
      cyc_q   <= 1'b0;
    end
    else if (st_q == ST_RESTART)
    begin
      // restart: aux off, active buses wake
      aux_q <= 1'b0;
      if (can_q[1])
        can_q <= TRX_WAKE;
      if (lin_q[1])
        lin_q <= TRX_WAKE;
    end
    // only normal or init may change
    else if (cfg_wr && addr == A_SUPPLY)
    begin
      aux_q   <= dat[SUP_AUX];
      boost_q <= dat[SUP_BOOST];
    end
    else if (cfg_wr && addr == A_BUS_CFG)
    begin
      can_q  <= dat[1:0];
      lin_q  <= dat[3:2];
      wken_q <= dat[BUS_WK_EN];
      cyc_q  <= dat[BUS_CYC_EN];
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  logic [7:0] sys_q;
  wire clr_st = eff_wr & (addr == A_SPI_STAT);
  wire clr_wk = eff_wr & (addr == A_WK_STAT);
  // no flag in init, nor before first supply rise while battery is low
  wire uv_set = ~sup_ok & (seen_q | bat_ok) & ~in_init;
  // select one fails at first miss
  wire fo_set = wd_exp & ~miss_ok & ~dev_q;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      seen_q  <= 1'b0;
      spi_f_q <= 1'b0;
      wd_f_q  <= 1'b0;
      uv_q    <= 1'b0;
      fail_q  <= 1'b0;
      wk_q    <= 6'h00;
      sys_q   <= SYS_RST;
    end
    else
    begin
      seen_q  <= seen_q | sup_ok;
      spi_f_q <= stop_bad | stop_slp
               | (spi_f_q & ~(clr_st & dat[ST_SPI_FAIL]));
      wd_f_q  <= wd_exp | (wd_f_q & ~(clr_st & dat[ST_WD_FAIL]));
      uv_q    <= uv_set | (uv_q & ~(clr_st & dat[ST_UV]));
      fail_q  <= fo_set | fail_q;
      wk_q    <= (in_init ? 6'h00 : wk_ev)
               | (wk_q & ~(clr_wk ? dat[5:0] : 6'h00));
      if (eff_wr && addr == A_SYS_STAT)
        sys_q <= dat;
    end
  end

  // ==========================================================
  // outputs
  // test bit drives fail outputs in normal mode only, the middle one only with fsi_fo_q set
  wire fail_output_test_bit = fail_q | (in_norm & fo_test_q);

  assign fail_outputs_o = {fail_output_test_bit, fail_output_test_bit & fsi_fo_q, fail_output_test_bit};
  assign fail_safe_input_active_o = ~fsi_fo_q;
  assign reset_output_n_o = rel_q;
  assign int_n_o          = ~|wk_q;
  assign mode_bits_o      = mode_q;
  assign state_o          = st_q;
  assign dev_config_o     = dev_q;
  assign spi_fail_o       = spi_f_q;
  assign wd_fail_o        = wd_f_q;
  assign main_supply_undervoltage_flag_o = uv_q;
  assign aux_supply_en_o  = aux_q;
  assign boost_en_o       = boost_q;
  assign can_mode_o       = can_q;
  assign lin_mode_o       = lin_q;
  assign wake_input_en_o  = wken_q;
  assign cyclic_wake_en_o = cyc_q;

endmodule : sbc_mode_ctrl

//--- design/sbc_mode_pkg.sv
package sbc_mode_pkg;

  // ==========================================================
  // clock and times
  localparam int unsigned CLK_MHZ   = 40;
  localparam int unsigned T_RD_US   = 10;
  localparam int unsigned T_LW_MS   = 200;
  localparam int unsigned T_WD_MS   = 20;
  localparam int unsigned RD_CYC    = T_RD_US * CLK_MHZ;
  localparam int unsigned LW_CYC_D  = T_LW_MS * 1000 * CLK_MHZ;
  localparam int unsigned WD_CYC_D  = T_WD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W     = 24;

  // ==========================================================
  // spi frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned WR_BIT     = 15;
  localparam int unsigned ADDR_HI    = 14;
  localparam int unsigned ADDR_LO    = 8;

  // ==========================================================
  // register addresses
  localparam logic [6:0] A_MODE     = 7'h01;
  localparam logic [6:0] A_HARDWARE_CONTROL_REGISTER  = 7'h02;
  localparam logic [6:0] A_WATCHDOG_CONTROL_REGISTER  = 7'h03;
  localparam logic [6:0] A_SYS_STAT = 7'h04;
  localparam logic [6:0] A_SPI_STAT = 7'h05;
  localparam logic [6:0] A_WK_STAT  = 7'h06;
  localparam logic [6:0] A_SUPPLY   = 7'h07;
  localparam logic [6:0] A_BUS_CFG  = 7'h08;

  // ==========================================================
  // field positions
  localparam int unsigned HW_CFG_SEL  = 0;
  localparam int unsigned HW_FSI_FO   = 1;
  localparam int unsigned HW_FO_TEST  = 2;
  localparam int unsigned WD_MAX3     = 0;
  localparam int unsigned ST_SPI_FAIL = 0;
  localparam int unsigned ST_WD_FAIL  = 1;
  localparam int unsigned ST_UV       = 2;
  localparam int unsigned SUP_AUX     = 0;
  localparam int unsigned SUP_BOOST   = 1;
  localparam int unsigned BUS_WK_EN   = 4;
  localparam int unsigned BUS_CYC_EN  = 5;

  // ==========================================================
  // encodings and reset values
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_SRST   = 2'h3;
  localparam logic [1:0] TRX_OFF     = 2'h0;
  localparam logic [1:0] TRX_WAKE    = 2'h1;
  localparam logic [1:0] TRX_RO      = 2'h2;
  localparam logic [1:0] TRX_NORMAL  = 2'h3;
  localparam logic [1:0] MISS_LIMIT  = 2'h3;
  localparam logic [7:0] SYS_RST     = 8'h00;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_NORMAL,
    ST_STOP,
    ST_SLEEP,
    ST_RESTART
  } sbc_state_t;

endpackage : sbc_mode_pkg

//--- design/spi_frame_rx.sv
`timescale 1ns/100ps
module spi_frame_rx
  import sbc_mode_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  input  wire logic [15:0] tx_word_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  output logic             frame_o,
  output logic [15:0]      rx_word_o
);

  // ==========================================================
  // three-stage pin synchronisers
  logic [2:0] s1_q, s2_q, s3_q, lvl_q, prv_q;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q, tx_q;

  always_ff @(posedge mclk_i)
  begin
    s1_q <= {sck_i, cs_n_i, mosi_i};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      lvl_q <= 3'h2;
      prv_q <= 3'h2;
    end
    else
    begin
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      prv_q <= lvl_q;
    end
  end

  // ==========================================================
  // edge decode
  wire cs_act  = ~lvl_q[1];
  wire sck_up  = lvl_q[2] & ~prv_q[2];
  wire sck_dn  = ~lvl_q[2] & prv_q[2];
  wire cs_fall = ~lvl_q[1] & prv_q[1];
  wire cs_rise = lvl_q[1] & ~prv_q[1];

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cnt_q     <= 5'h00;
      sh_q      <= 16'h0000;
      tx_q      <= 16'h0000;
      frame_o   <= 1'b0;
      rx_word_o <= 16'h0000;
    end
    else
    begin
      frame_o <= 1'b0;
      if (cs_fall)
      begin
        cnt_q <= 5'h00;
        tx_q  <= tx_word_i;
      end
      else if (cs_act && sck_up)
      begin
        sh_q  <= {sh_q[14:0], lvl_q[0]};
        cnt_q <= cnt_q + 5'h01;
      end
      else if (cs_act && sck_dn)
        tx_q <= {tx_q[14:0], 1'b0};
      // only whole 16-bit frames count
      if (cs_rise && cnt_q == 5'(FRAME_BITS))
      begin
        frame_o   <= 1'b1;
        rx_word_o <= sh_q;
      end
    end
  end

  assign miso_o    = tx_q[15];
  assign miso_oe_o = cs_act;

endmodule : spi_frame_rx
